// ---- pcrs_host_model.sv ----
// Purpose: host controller issuing framed commands to the register set
// Assumes: a request is taken at the first rising edge it is shown
// Notes:   released command lines toggle so a stale value is never seen
`timescale 1ns/100ps

module pcrs_host_model
  import pcrs_pkg::*;
(
  input  wire logic      core_clk,
  output logic           reqValid,
  output pcrs_req_t      req,
  input  wire pcrs_rsp_t rsp
);
  initial begin
    reqValid = 1'b0;
    req      = '0;
  end

  // got stays low when the device never answers
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] c,
                      input logic [15:0] d, output pcrs_rsp_t r, output logic got);
    got = 1'b0;
    r   = '0;
    @(negedge core_clk);
    reqValid = 1'b1;
    req      = '{write: wr, addr: a, code: c, data: d};
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      reqValid = 1'b0;
      req      = ~req;
      if (!got && rsp.valid === 1'b1) begin
        got = 1'b1;
        r   = rsp;
      end
    end
  endtask
endmodule

// ---- pcrs_pkg.sv ----
// Purpose: constants, command codes and carriers of the converter command register set
// Assumes: command framing, address and data bytes come from the bus interface logic
// Notes:   all linear-format values are held as raw 16-bit words
//
// How it works
// - writing code 03h clears every fault status bit and drops the alert output, except bits of a fault event arriving in the same cycle
// - code 01h turns output on or off; steering set by enable config; volatile
// - code 02h picks pin and command combination; resets to 16h; storable
// - code 10h gates writes to operating registers; resets 00h; storable
// - codes 11h and 15h copy every storable setting into the nonvolatile image
// - codes 12h and 16h reload every storable setting from the nonvolatile image
// - read-only code 19h returns B0h
// - code 1Bh masks status bits from the alert; power-good-low masked by default
// - read-only code 20h returns 17h
// - code 24h upper clamp on setpoint; restore value follows loop scaling; setpoint 0133h
// - code 2Bh lower clamp on setpoint; restore value follows loop scaling
// - code 27h slew rate, reset D03Ch, volatile
// - code 29h loop scaling ratio, reset F004h, storable, picks clamp restore values
// - codes 35h/36h start and stop input thresholds, F012h and F010h, storable
// - code 39h current sense offset, reset E000h, storable
// - code 41h overvoltage response, reset BFh, storable
// - code 45h undervoltage response, reset BFh, storable
// - code 46h overcurrent fault level, reset F854h, storable
// - code 47h overcurrent response, reset FFh, storable
// - code 4Ah overcurrent warning level, reset F84Ah, volatile
// - answer only at bus address 36 as loop master or 37 as loop slave
// - output enable follows pin alone, command alone, both together, or neither (run whenever powered)
package pcrs_pkg;

  // ----------------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_ON_OFF     = 8'h01;
  localparam logic [7:0] CMD_EN_CFG     = 8'h02;
  localparam logic [7:0] CMD_CLR_FAULT  = 8'h03;
  localparam logic [7:0] CMD_WR_LOCK    = 8'h10;
  localparam logic [7:0] CMD_SAVE_DEF   = 8'h11;
  localparam logic [7:0] CMD_LOAD_DEF   = 8'h12;
  localparam logic [7:0] CMD_SAVE_USR   = 8'h15;
  localparam logic [7:0] CMD_LOAD_USR   = 8'h16;
  localparam logic [7:0] CMD_FEATURE    = 8'h19;
  localparam logic [7:0] CMD_ALERT_MASK = 8'h1B;
  localparam logic [7:0] CMD_FORMAT     = 8'h20;
  localparam logic [7:0] CMD_SETPOINT   = 8'h21;
  localparam logic [7:0] CMD_UPPER      = 8'h24;
  localparam logic [7:0] CMD_SLEW       = 8'h27;
  localparam logic [7:0] CMD_SCALE      = 8'h29;
  localparam logic [7:0] CMD_LOWER      = 8'h2B;
  localparam logic [7:0] CMD_VIN_START  = 8'h35;
  localparam logic [7:0] CMD_VIN_STOP   = 8'h36;
  localparam logic [7:0] CMD_CUR_OFS    = 8'h39;
  localparam logic [7:0] CMD_OV_RESP    = 8'h41;
  localparam logic [7:0] CMD_UV_RESP    = 8'h45;
  localparam logic [7:0] CMD_OC_LEVEL   = 8'h46;
  localparam logic [7:0] CMD_OC_RESP    = 8'h47;
  localparam logic [7:0] CMD_OC_WARN    = 8'h4A;

  // ----------------------------------------------------------------------
  // addresses (36 and 37 decimal), fixed values, bit positions
  // ----------------------------------------------------------------------
  localparam logic [6:0]  BUS_ADDR_MASTER = 7'h24;
  localparam logic [6:0]  BUS_ADDR_SLAVE  = 7'h25;
  localparam logic [7:0]  FEATURE_VALUE   = 8'hB0;
  localparam logic [7:0]  FORMAT_VALUE    = 8'h17;
  localparam logic [15:0] SCALE_ONE       = 16'hF004;
  localparam logic [15:0] SCALE_HALF      = 16'hF002;
  localparam logic [15:0] SCALE_QUARTER   = 16'hF001;
  localparam logic [15:0] UPPER_ONE       = 16'h034D;
  localparam logic [15:0] UPPER_HALF      = 16'h069A;
  localparam logic [15:0] UPPER_QUARTER   = 16'h0C00;
  localparam logic [15:0] LOWER_ONE       = 16'h00B3;
  localparam logic [15:0] LOWER_HALF      = 16'h0166;
  localparam logic [15:0] LOWER_QUARTER   = 16'h02CC;
  localparam int          ON_BIT          = 7;  // output on in the on/off command
  localparam int          CFG_PU_BIT      = 4;  // 0: run whenever powered
  localparam int          CFG_CMD_BIT     = 3;  // command must be on
  localparam int          CFG_PIN_BIT     = 2;  // pin must be active
  localparam int          CFG_POL_BIT     = 1;  // 1: pin active high
  localparam int          LOCK_ALL_BIT    = 7;
  localparam int          LOCK_OP_BIT     = 6;
  localparam int          LOCK_CFG_BIT    = 5;
  localparam int          ST_CML_BIT      = 1;  // communication fault
  localparam int          ST_PGOOD_BIT    = 3;  // power-good-low

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        write;
    logic [6:0]  addr;
    logic [7:0]  code;
    logic [15:0] data;
  } pcrs_req_t;

  typedef struct packed {
    logic        valid;
    logic        nack;
    logic [15:0] data;
  } pcrs_rsp_t;

  typedef struct packed {
    logic [7:0]  enableCfg;
    logic [7:0]  writeLock;
    logic [7:0]  alertMask;
    logic [15:0] setpoint;
    logic [15:0] scaleRatio;
    logic [15:0] startThresh;
    logic [15:0] stopThresh;
    logic [15:0] curOffset;
    logic [7:0]  ovResp;
    logic [7:0]  uvResp;
    logic [15:0] ocLevel;
    logic [7:0]  ocResp;
  } pcrs_store_t;

  typedef struct packed {
    logic [7:0]  onOff;
    logic [15:0] upperClamp;
    logic [15:0] slewRate;
    logic [15:0] lowerClamp;
    logic [15:0] ocWarn;
  } pcrs_vol_t;

  localparam pcrs_store_t STORE_RESET = '{
    enableCfg:   8'h16,
    writeLock:   8'h00,
    alertMask:   8'h08,
    setpoint:    16'h0133,
    scaleRatio:  16'hF004,
    startThresh: 16'hF012,
    stopThresh:  16'hF010,
    curOffset:   16'hE000,
    ovResp:      8'hBF,
    uvResp:      8'hBF,
    ocLevel:     16'hF854,
    ocResp:      8'hFF
  };

  localparam pcrs_vol_t VOL_RESET = '{
    onOff:      8'h80,
    upperClamp: 16'h034D,
    slewRate:   16'hD03C,
    lowerClamp: 16'h00B3,
    ocWarn:     16'hF84A
  };

endpackage

// ---- pcrs_register_set.sv ----
// Purpose: command register set of a digitally managed step-down converter
// Assumes: one request per valid cycle, already framed and byte-assembled
// Notes:   nonvolatile image is modelled as a register bank beside the live set
`timescale 1ns/100ps

module pcrs_register_set
  import pcrs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        reqValid,
  input  wire pcrs_req_t   req,
  input  wire logic        controlPin,
  input  wire logic        isLoopSlave,
  input  wire logic [7:0]  faultEvents,
  output pcrs_rsp_t        rsp,
  output logic             outputOn,
  output logic             alertOut,
  output logic [7:0]       faultStatus,
  output pcrs_store_t      cfgStore,
  output pcrs_vol_t        cfgVol,
  output logic [15:0]      setpointEff
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  pcrs_store_t store_r;
  pcrs_store_t store_nxt;
  pcrs_store_t image_r;
  pcrs_store_t image_nxt;
  pcrs_vol_t   vol_r;
  pcrs_vol_t   vol_nxt;
  pcrs_rsp_t   rsp_r;
  pcrs_rsp_t   rsp_nxt;
  logic [7:0]  status_r;
  logic [7:0]  status_nxt;
  logic        alert_r;
  logic        outOn_r;
  logic [15:0] spEff_r;

  // ----------------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------------
  wire logic [6:0] ownAddr  = isLoopSlave ? BUS_ADDR_SLAVE : BUS_ADDR_MASTER;
  wire logic       addrHit  = (req.addr == ownAddr);
  wire logic       isWr     = reqValid & addrHit & req.write;
  wire logic       isRd     = reqValid & addrHit & ~req.write;
  wire logic [7:0] code     = req.code;
  wire logic [7:0] data8    = req.data[7:0];
  wire logic [15:0] data16  = req.data;

  wire logic codeRw = (code == CMD_ON_OFF)    | (code == CMD_EN_CFG)    |
                      (code == CMD_WR_LOCK)   | (code == CMD_ALERT_MASK)|
                      (code == CMD_SETPOINT)  | (code == CMD_UPPER)     |
                      (code == CMD_SLEW)      | (code == CMD_SCALE)     |
                      (code == CMD_LOWER)     | (code == CMD_VIN_START) |
                      (code == CMD_VIN_STOP)  | (code == CMD_CUR_OFS)   |
                      (code == CMD_OV_RESP)   | (code == CMD_UV_RESP)   |
                      (code == CMD_OC_LEVEL)  | (code == CMD_OC_RESP)   |
                      (code == CMD_OC_WARN);
  wire logic codeRo = (code == CMD_FEATURE) | (code == CMD_FORMAT);
  wire logic codeClr     = (code == CMD_CLR_FAULT);
  wire logic codeSave    = (code == CMD_SAVE_DEF) | (code == CMD_SAVE_USR);
  wire logic codeRestore = (code == CMD_LOAD_DEF) | (code == CMD_LOAD_USR);

  // ----------------------------------------------------------------------
  // write lock
  // ----------------------------------------------------------------------
  wire logic [7:0] lockVal = store_r.writeLock;
  wire logic exemptAll = (code == CMD_WR_LOCK);
  wire logic exemptOp  = exemptAll | (code == CMD_ON_OFF);
  wire logic exemptCfg = exemptOp | (code == CMD_EN_CFG) | (code == CMD_SETPOINT);
  wire logic lockOk = lockVal[LOCK_ALL_BIT] ? exemptAll :
                      lockVal[LOCK_OP_BIT]  ? exemptOp  :
                      lockVal[LOCK_CFG_BIT] ? exemptCfg : 1'b1;

  wire logic wrHit      = isWr & codeRw & lockOk;
  wire logic clrHit     = isWr & codeClr;
  wire logic saveHit    = isWr & codeSave;
  wire logic restoreHit = isWr & codeRestore & (lockVal == 8'h00);
  wire logic wrBad = isWr & ~(wrHit | clrHit | saveHit | restoreHit);
  wire logic rdBad = isRd & ~(codeRw | codeRo);
  wire logic badAccess = wrBad | rdBad;

  // ----------------------------------------------------------------------
  // clamp restore values follow the loop scaling
  // ----------------------------------------------------------------------
  wire logic [15:0] newScale = image_r.scaleRatio;
  wire logic [15:0] upperRestore = (newScale == SCALE_HALF)    ? UPPER_HALF    :
                                   (newScale == SCALE_QUARTER) ? UPPER_QUARTER :
                                   UPPER_ONE;
  wire logic [15:0] lowerRestore = (newScale == SCALE_HALF)    ? LOWER_HALF    :
                                   (newScale == SCALE_QUARTER) ? LOWER_QUARTER :
                                   LOWER_ONE;

  // ----------------------------------------------------------------------
  // read selection
  // ----------------------------------------------------------------------
  function automatic logic [15:0] readMux(input logic [7:0] c,
                                          input pcrs_store_t s,
                                          input pcrs_vol_t v);
    logic [15:0] r;
    r = 16'h0000;
    case (c)
      CMD_ON_OFF:     r = {8'h00, v.onOff};
      CMD_EN_CFG:     r = {8'h00, s.enableCfg};
      CMD_WR_LOCK:    r = {8'h00, s.writeLock};
      CMD_FEATURE:    r = {8'h00, FEATURE_VALUE};
      CMD_ALERT_MASK: r = {8'h00, s.alertMask};
      CMD_FORMAT:     r = {8'h00, FORMAT_VALUE};
      CMD_SETPOINT:   r = s.setpoint;
      CMD_UPPER:      r = v.upperClamp;
      CMD_SLEW:       r = v.slewRate;
      CMD_SCALE:      r = s.scaleRatio;
      CMD_LOWER:      r = v.lowerClamp;
      CMD_VIN_START:  r = s.startThresh;
      CMD_VIN_STOP:   r = s.stopThresh;
      CMD_CUR_OFS:    r = s.curOffset;
      CMD_OV_RESP:    r = {8'h00, s.ovResp};
      CMD_UV_RESP:    r = {8'h00, s.uvResp};
      CMD_OC_LEVEL:   r = s.ocLevel;
      CMD_OC_RESP:    r = {8'h00, s.ocResp};
      CMD_OC_WARN:    r = v.ocWarn;
      default:        r = 16'h0000;
    endcase
    return r;
  endfunction

  wire logic [15:0] rdData = readMux(code, store_r, vol_r);

  // ----------------------------------------------------------------------
  // storable settings: host writes and reload from the image
  // ----------------------------------------------------------------------
  always_comb begin
    store_nxt = store_r;
    if (restoreHit) begin
      store_nxt = image_r;
    end else if (wrHit) begin
      case (code)
        CMD_EN_CFG:     store_nxt.enableCfg   = data8;
        CMD_WR_LOCK:    store_nxt.writeLock   = data8;
        CMD_ALERT_MASK: store_nxt.alertMask   = data8;
        CMD_SETPOINT:   store_nxt.setpoint    = data16;
        CMD_SCALE:      store_nxt.scaleRatio  = data16;
        CMD_VIN_START:  store_nxt.startThresh = data16;
        CMD_VIN_STOP:   store_nxt.stopThresh  = data16;
        CMD_CUR_OFS:    store_nxt.curOffset   = data16;
        CMD_OV_RESP:    store_nxt.ovResp      = data8;
        CMD_UV_RESP:    store_nxt.uvResp      = data8;
        CMD_OC_LEVEL:   store_nxt.ocLevel     = data16;
        CMD_OC_RESP:    store_nxt.ocResp      = data8;
        default:        store_nxt = store_r;
      endcase
    end
  end

  // image only changes on an explicit save command or at reset
  assign image_nxt = saveHit ? store_r : image_r;

  // ----------------------------------------------------------------------
  // volatile settings
  // ----------------------------------------------------------------------
  always_comb begin
    vol_nxt = vol_r;
    if (restoreHit) begin
      vol_nxt.upperClamp = upperRestore;
      vol_nxt.lowerClamp = lowerRestore;
    end else if (wrHit) begin
      case (code)
        CMD_ON_OFF:  vol_nxt.onOff      = data8;
        CMD_UPPER:   vol_nxt.upperClamp = data16;
        CMD_SLEW:    vol_nxt.slewRate   = data16;
        CMD_LOWER:   vol_nxt.lowerClamp = data16;
        CMD_OC_WARN: vol_nxt.ocWarn     = data16;
        default:     vol_nxt = vol_r;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // fault status and alert; a new event wins over a clear
  // ----------------------------------------------------------------------
  wire logic [7:0] cmlEvent = {6'b00_0000, badAccess, 1'b0};
  wire logic [7:0] faultSet = faultEvents | cmlEvent;
  assign status_nxt = clrHit ? faultSet : (status_r | faultSet);
  wire logic alertNxt = |(status_nxt & ~store_nxt.alertMask);

  // ----------------------------------------------------------------------
  // output enable steering
  // ----------------------------------------------------------------------
  wire logic [7:0] cfgNow = store_nxt.enableCfg;
  wire logic pinActive = cfgNow[CFG_POL_BIT] ? controlPin : ~controlPin;
  wire logic cmdOn     = vol_nxt.onOff[ON_BIT];
  wire logic needCmd   = cfgNow[CFG_CMD_BIT];
  wire logic needPin   = cfgNow[CFG_PIN_BIT];
  wire logic outOnNxt  = ~cfgNow[CFG_PU_BIT] |
                         ((~needCmd | cmdOn) & (~needPin | pinActive));

  // ----------------------------------------------------------------------
  // setpoint clamp
  // ----------------------------------------------------------------------
  wire logic [15:0] spReq = store_nxt.setpoint;
  wire logic [15:0] spEffNxt = (spReq > vol_nxt.upperClamp) ? vol_nxt.upperClamp :
                               (spReq < vol_nxt.lowerClamp) ? vol_nxt.lowerClamp :
                               spReq;

  // ----------------------------------------------------------------------
  // response
  // ----------------------------------------------------------------------
  assign rsp_nxt.valid = isWr | isRd;
  assign rsp_nxt.nack  = badAccess;
  assign rsp_nxt.data  = (isRd & ~rdBad) ? rdData : 16'h0000;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      store_r  <= STORE_RESET;
      image_r  <= STORE_RESET;
      vol_r    <= VOL_RESET;
      status_r <= 8'h00;
    end else begin
      store_r  <= store_nxt;
      image_r  <= image_nxt;
      vol_r    <= vol_nxt;
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rsp_r   <= '0;
      alert_r <= 1'b0;
      outOn_r <= 1'b0;
      spEff_r <= 16'h0000;
    end else begin
      rsp_r   <= rsp_nxt;
      alert_r <= alertNxt;
      outOn_r <= outOnNxt;
      spEff_r <= spEffNxt;
    end
  end

  assign rsp         = rsp_r;
  assign alertOut    = alert_r;
  assign outputOn    = outOn_r;
  assign faultStatus = status_r;
  assign cfgStore    = store_r;
  assign cfgVol      = vol_r;
  assign setpointEff = spEff_r;

endmodule

// ---- pcrs_register_set_checker.sv ----
// Purpose: port-level checks of the command register set
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every instance of the register set
`timescale 1ns/100ps

module pcrs_register_set_checker
  import pcrs_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        reqValid,
  input wire pcrs_req_t   req,
  input wire logic        controlPin,
  input wire logic        isLoopSlave,
  input wire logic [7:0]  faultEvents,
  input wire pcrs_rsp_t   rsp,
  input wire logic        outputOn,
  input wire logic        alertOut,
  input wire logic [7:0]  faultStatus,
  input wire pcrs_store_t cfgStore,
  input wire pcrs_vol_t   cfgVol,
  input wire logic [15:0] setpointEff
);
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  wire logic [6:0] ownAddr = isLoopSlave ? BUS_ADDR_SLAVE : BUS_ADDR_MASTER;
  wire logic       taken   = reqValid && req.addr == ownAddr;

  function automatic logic known(input logic [7:0] c);
    return c inside {8'h01, 8'h02, 8'h03, 8'h10, 8'h11, 8'h12, 8'h15, 8'h16, 8'h19,
      8'h1B, 8'h20, 8'h21, 8'h24, 8'h27, 8'h29, 8'h2B, 8'h35, 8'h36, 8'h39, 8'h41,
      8'h45, 8'h46, 8'h47, 8'h4A};
  endfunction

  function automatic logic [15:0] clampf(input logic [15:0] v, lo, hi);
    return (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction

  sequence s_taken(logic [7:0] c, logic w);
    taken && req.code == c && req.write == w;
  endsequence

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_own_answer: assert property (taken |=> rsp.valid)
    else $error("request to own address not answered");
  a_no_foreign: assert property (!taken |=> !rsp.valid)
    else $error("answer without a request to own address");
  a_feature_read: assert property (s_taken(CMD_FEATURE, 1'b0) |=>
    !rsp.nack && rsp.data == 16'h00B0) else $error("feature report value wrong");
  a_clear_faults: assert property (s_taken(CMD_CLR_FAULT, 1'b1) ##0 faultEvents == 8'h00 |=>
    faultStatus == 8'h00 && !alertOut) else $error("fault clear left status or alert");
  a_bad_nack: assert property (taken && !known(req.code) |=>
    rsp.nack && faultStatus[ST_CML_BIT]) else $error("unsupported code not refused");
  a_bad_hold: assert property (taken && !known(req.code) |=>
    $stable(cfgStore) && $stable(cfgVol)) else $error("unsupported code changed a register");
  a_lock_blocks: assert property (s_taken(CMD_SETPOINT, 1'b1) ##0 cfgStore.writeLock[7:6] != 2'b00
    |=> rsp.nack && $stable(cfgStore.setpoint)) else $error("locked setpoint was written");
  a_clamp_eff: assert property (!sys_rst |=>
    setpointEff == clampf(cfgStore.setpoint, cfgVol.lowerClamp, cfgVol.upperClamp))
    else $error("effective setpoint not clamped");
  a_alert_mask: assert property ($stable(cfgStore.alertMask) |->
    alertOut == |(faultStatus & ~cfgStore.alertMask)) else $error("alert disagrees with mask");
endmodule

bind pcrs_register_set pcrs_register_set_checker pcrs_register_set_checker_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .reqValid(reqValid), .req(req),
  .controlPin(controlPin), .isLoopSlave(isLoopSlave), .faultEvents(faultEvents),
  .rsp(rsp), .outputOn(outputOn), .alertOut(alertOut), .faultStatus(faultStatus),
  .cfgStore(cfgStore), .cfgVol(cfgVol), .setpointEff(setpointEff));

// ---- pcrs_register_set_test.sv ----
// Purpose: self-checking bench of the command register set
// Assumes: host model frames every command
// Notes:   seeded random setpoints, on/off commands and pin levels among fixed corners and enable settings
`timescale 1ns/100ps

module pcrs_register_set_test import pcrs_pkg::*;;
  logic core_clk, sys_rst, reqValid, controlPin, isLoopSlave, outputOn, alertOut;
  logic [7:0]  faultEvents, faultStatus;
  logic [15:0] setpointEff;
  logic [6:0]  ownAddr;
  pcrs_req_t   req;
  pcrs_rsp_t   rsp;
  pcrs_store_t cfgStore;
  pcrs_vol_t   cfgVol;
  int          nErrors = 0;
  int          nChecks = 0;
  localparam logic [7:0] RCODE [19] = '{8'h01, 8'h02, 8'h10, 8'h1B, 8'h21, 8'h24, 8'h27,
    8'h29, 8'h2B, 8'h35, 8'h36, 8'h39, 8'h41, 8'h45, 8'h46, 8'h47, 8'h4A, 8'h19, 8'h20};
  localparam logic [15:0] RVAL [19] = '{16'h0080, 16'h0016, 16'h0000, 16'h0008, 16'h0133,
    16'h034D, 16'hD03C, 16'hF004, 16'h00B3, 16'hF012, 16'hF010, 16'hE000, 16'h00BF,
    16'h00BF, 16'hF854, 16'h00FF, 16'hF84A, 16'h00B0, 16'h0017};
  localparam logic [7:0] CFGS [5] = '{8'h16, 8'h1A, 8'h1E, 8'h14, 8'h0A};

  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  pcrs_register_set pcrs_register_set_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .reqValid(reqValid), .req(req), .controlPin(controlPin), .isLoopSlave(isLoopSlave),
    .faultEvents(faultEvents), .rsp(rsp), .outputOn(outputOn), .alertOut(alertOut),
    .faultStatus(faultStatus), .cfgStore(cfgStore), .cfgVol(cfgVol),
    .setpointEff(setpointEff));
  pcrs_host_model pcrs_host_model_inst (.core_clk(core_clk), .reqValid(reqValid),
    .req(req), .rsp(rsp));

  function automatic logic [15:0] clampf(input logic [15:0] v, lo, hi);
    return (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction
  function automatic logic onf(input logic [7:0] cfg, input logic on, pin);
    return !cfg[4] || ((!cfg[3] || on) && (!cfg[2] || pin == cfg[1]));
  endfunction

  task automatic chkWord(input string name, input logic [15:0] exp, got);
    nChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chkBit(input string name, input logic exp, got);
    chkWord(name, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic finishTest;
    $display("checks %0d errors %0d", nChecks, nErrors);
    if (nErrors == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic nk);
    pcrs_rsp_t r;
    logic      g;
    pcrs_host_model_inst.xfer(1'b1, ownAddr, c, d, r, g);
    chkBit("write answered", 1'b1, g);
    chkBit("write refused", nk, r.nack);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    pcrs_rsp_t r;
    logic      g;
    pcrs_host_model_inst.xfer(1'b0, ownAddr, c, 16'h0000, r, g);
    chkBit("read answered", 1'b1, g);
    chkWord("read data", e, r.data);
  endtask

  initial begin
    #200000;
    nErrors++;
    finishTest();
  end

  initial begin
    logic [15:0] d;
    logic [7:0]  cfg;
    pcrs_rsp_t   r;
    logic        g;
    sys_rst = 1'b1;
    controlPin = 1'b0;
    isLoopSlave = 1'b0;
    faultEvents = 8'h00;
    ownAddr = BUS_ADDR_MASTER;
    void'($urandom(32'h5be9_ecf1));
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 19; i++) rd(RCODE[i], RVAL[i]);
    for (int i = 0; i < 14; i++) begin
      d = (i == 0) ? 16'h0000 : ((i == 1) ? 16'hFFFF : 16'($urandom));
      wr(CMD_SETPOINT, d, 1'b0);
      wr(CMD_SLEW, ~d, 1'b0);
      rd(CMD_SETPOINT, d);
      rd(CMD_SLEW, ~d);
      chkWord("clamped setpoint", clampf(d, 16'h00B3, 16'h034D), setpointEff);
    end
    pcrs_host_model_inst.xfer(1'b0, BUS_ADDR_SLAVE, CMD_FEATURE, 16'h0000, r, g);
    chkBit("foreign address ignored", 1'b0, g);
    isLoopSlave = 1'b1;
    ownAddr = BUS_ADDR_SLAVE;
    rd(CMD_FEATURE, 16'h00B0);
    isLoopSlave = 1'b0;
    ownAddr = BUS_ADDR_MASTER;
    wr(8'h05, 16'h0000, 1'b1);
    chkWord("status after bad code", 16'h0002, {8'h00, faultStatus});
    chkBit("alert after bad code", 1'b1, alertOut);
    wr(CMD_FORMAT, d, 1'b1);
    wr(CMD_CLR_FAULT, 16'h0000, 1'b0);
    chkWord("status after clear", 16'h0000, {8'h00, faultStatus});
    chkBit("alert after clear", 1'b0, alertOut);
    for (int i = 0; i < 2; i++) begin
      faultEvents = i ? 8'h04 : 8'h08;
      @(negedge core_clk);
      faultEvents = 8'h00;
      @(negedge core_clk);
      chkBit("alert from event", i[0], alertOut);
    end
    wr(CMD_CLR_FAULT, 16'h0000, 1'b0);
    for (int i = 0; i < 2; i++) begin
      wr(CMD_SCALE, i ? 16'hF001 : 16'hF002, 1'b0);
      wr(i ? CMD_SAVE_USR : CMD_SAVE_DEF, 16'h0000, 1'b0);
      wr(CMD_SCALE, 16'hF004, 1'b0);
      wr(CMD_SETPOINT, ~d, 1'b0);
      wr(i ? CMD_LOAD_USR : CMD_LOAD_DEF, 16'h0000, 1'b0);
      rd(CMD_SCALE, i ? 16'hF001 : 16'hF002);
      rd(CMD_SETPOINT, d);
      rd(CMD_UPPER, i ? 16'h0C00 : 16'h069A);
      rd(CMD_LOWER, i ? 16'h02CC : 16'h0166);
    end
    wr(CMD_WR_LOCK, 16'h0040, 1'b0);
    wr(CMD_SETPOINT, 16'h0100, 1'b1);
    wr(CMD_LOAD_USR, 16'h0000, 1'b1);
    wr(CMD_WR_LOCK, 16'h0080, 1'b0);
    wr(CMD_ON_OFF, 16'h0000, 1'b1);
    rd(CMD_ON_OFF, 16'h0080);
    wr(CMD_WR_LOCK, 16'h0020, 1'b0);
    wr(CMD_SCALE, 16'hF004, 1'b1);
    wr(CMD_WR_LOCK, 16'h0000, 1'b0);
    wr(CMD_SETPOINT, 16'h0100, 1'b0);
    wr(CMD_CLR_FAULT, 16'h0000, 1'b0);
    for (int i = 0; i < 15; i++) begin
      cfg = CFGS[i % 5];
      d = 16'($urandom);
      wr(CMD_EN_CFG, {8'h00, cfg}, 1'b0);
      wr(CMD_ON_OFF, {8'h00, d[0], 7'h00}, 1'b0);
      controlPin = d[1];
      repeat (2) @(negedge core_clk);
      chkBit("output enable", onf(cfg, d[0], d[1]), outputOn);
    end
    finishTest();
  end
endmodule
